// ### pkg/iec_pkg.sv
// Constants shared by the interval and event counter block
package iec_pkg;
  // Register indices on the plain register port
  localparam logic [3:0] ADR_RUN_CTL    = 4'h0;
  localparam logic [3:0] ADR_MODE_CTL   = 4'h1;
  localparam logic [3:0] ADR_OUT_CTL    = 4'h2;
  localparam logic [3:0] ADR_EDGE_CTL   = 4'h3;
  localparam logic [3:0] ADR_PERIOD     = 4'h4;
  localparam logic [3:0] ADR_AUX1       = 4'h5;
  localparam logic [3:0] ADR_AUX2       = 4'h6;
  localparam logic [3:0] ADR_AUX3       = 4'h7;
  localparam logic [3:0] ADR_COUNT      = 4'h8;
  localparam logic [3:0] ADR_IRQ_STATUS = 4'h9;
  localparam logic [3:0] ADR_IRQ_MASK   = 4'hA;
  // Field positions
  localparam int RUN_BIT       = 7;
  localparam int EXT_CLK_BIT   = 5;
  localparam int EDGE_LSB      = 2;
  localparam int ST_PERIOD_BIT = 0;
  localparam int ST_WRAP_BIT   = 4;
  // Mode field encodings
  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [2:0] MODE_EVENT    = 3'h1;
  // Edge select encodings
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Values after reset
  localparam logic [7:0]  RST_CTL    = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [4:0]  RST_IRQ    = 5'h00;
  localparam logic [6:0]  RST_DIV    = 7'h00;
endpackage

// ### verilog/iec_timer_channel.sv
// 16-bit timer channel: interval mode and external event count mode
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Mode 000 selects interval, count clock ticks.
// - Period match clears counter, toggles pin, interrupts.
// - Zero period: counter stays zero, match each tick.
// - All-ones period wraps to zero with match.
// - Match wrap never sets overflow flag.
// - Period write goes to shadow at once.
// - Period below count: run through wrap first.
// - Aux compare below period: match, toggle once.
// - Aux output period equals period output period.
// - Aux compare above period: no match, no toggle.
// - Mode 001 selects event count.
// - Event mode counts valid edges while running.
// - Run set: counter FFFF to 0, shadow loaded.
// - Event match clears counter, raises period interrupt.
// - Event mode drives no period waveform.
module iec_timer_channel
  import iec_pkg::*;
(
  input  wire logic        sys_clk_i,             // System clock, 50 MHz
  input  wire logic        rst_n_i,               // Asynchronous reset, active low
  input  wire logic [3:0]  addr_i,                // Register index
  input  wire logic [15:0] wdata_i,               // Write data
  input  wire logic        wr_i,                  // Write strobe
  input  wire logic        rd_i,                  // Read strobe
  output logic      [15:0] rdata_o,               // Read data, cycle after strobe
  input  wire logic        event_input_pin_i,     // External event pin, asynchronous
  output logic             period_toggle_out_o,   // Period output pin level
  output logic      [2:0]  aux_toggle_out_o,      // Auxiliary output pin levels
  output logic             irq_o                  // Level interrupt
);
  import iec_pkg::*;

  // Software registers
  // Byte registers keep control bits in their low byte; compare values are full
  // words. Count is absent here because hardware writes it; status is here because software clears it.
  logic [7:0]  run_and_prescale_control;  // Run bit and prescale select
  logic [7:0]  mode_and_trigger_control;  // Mode field and clock source
  logic [7:0]  output_pin_control;        // Pin enables and idle levels
  logic [7:0]  edge_select_control;       // Event edge select
  logic [15:0] period_compare_reg;        // Software period value
  logic [15:0] aux_compare_reg [3];       // Auxiliary compare values
  logic [4:0]  irq_status;                // Sticky event bits
  logic [4:0]  irq_mask;                  // Interrupt enables

  // Counting state
  // The counter rests at all ones while stopped; started marks that the run
  // has left that resting value, so no compare fires on the start tick.
  logic [15:0] counter;                   // Internal 16-bit counter
  logic [15:0] period_shadow;             // Value compared against counter
  logic        started;                   // Counter has left all ones since run set
  logic        run_q;                     // Run bit delayed, for rise detect
  logic        period_out_q;              // Period toggle flop
  logic [2:0]  aux_out_q;                 // Aux toggle flops
  logic [6:0]  div_cnt;                   // Prescale divider
  logic [2:0]  ev_sync;                   // Event sync chain and edge history

  // Decoded controls
  // Field slices are named once here so the processes below read as the
  // hardware they describe rather than as bit positions.
  logic        run_control_bit;
  logic [2:0]  clock_prescale_select;
  logic [2:0]  mode_select_field;
  logic        external_clock_select;
  logic [1:0]  event_edge_select;
  logic        mode_interval;
  logic        mode_event;
  logic        run_rise;
  logic        presc_tick;
  logic        edge_pulse;
  logic        count_tick;
  logic        period_match;
  logic [2:0]  aux_match;
  logic        wrap_event;
  logic [4:0]  irq_set;
  logic [6:0]  div_mask;

  assign run_control_bit       = run_and_prescale_control[RUN_BIT];
  assign clock_prescale_select = run_and_prescale_control[2:0];
  assign mode_select_field     = mode_and_trigger_control[2:0];
  assign external_clock_select = mode_and_trigger_control[EXT_CLK_BIT];
  assign event_edge_select     = edge_select_control[EDGE_LSB+1:EDGE_LSB];
  assign mode_interval = (mode_select_field == MODE_INTERVAL);
  assign mode_event    = (mode_select_field == MODE_EVENT);
  assign run_rise      = run_control_bit & ~run_q;

  // Register writes; strobes are single cycle, so no write collides with itself
  // Period shadow, status and aux writes are decoded in their own processes, which
  // keeps each register beside the logic that owns it.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      run_and_prescale_control <= RST_CTL;
      mode_and_trigger_control <= RST_CTL;
      output_pin_control       <= RST_CTL;
      edge_select_control      <= RST_CTL;
      period_compare_reg       <= RST_WORD;
      irq_mask                 <= RST_IRQ;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        ADR_RUN_CTL:  run_and_prescale_control <= wdata_i[7:0];
        ADR_MODE_CTL: mode_and_trigger_control <= wdata_i[7:0];
        ADR_OUT_CTL:  output_pin_control       <= wdata_i[7:0];
        ADR_EDGE_CTL: edge_select_control      <= wdata_i[7:0];
        ADR_PERIOD:   period_compare_reg       <= wdata_i;
        ADR_IRQ_MASK: irq_mask                 <= wdata_i[4:0];
        default:      ;  // Other indices are written elsewhere, read-only or unmapped
      endcase
    end
  end

  // Aux compare registers, one per channel
  // Index 0 of the array is channel 1, matching bit 0 of the aux pins
  genvar k;
  generate
    for (k = 0; k < 3; k++)
    begin : g_aux_reg
      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          aux_compare_reg[k] <= RST_WORD;
        else if (wr_i && (addr_i == ADR_AUX1 + 4'(k)))
          aux_compare_reg[k] <= wdata_i;
      end
    end
  endgenerate

  // Read data is registered so it stands exactly in the cycle after the strobe
  // Outside that cycle the port reads zero, so a stale word can never be
  // mistaken for a fresh one by a master that samples late.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= RST_WORD;
    else if (rd_i)
    begin
      unique case (addr_i)
        ADR_RUN_CTL:    rdata_o <= {8'h00, run_and_prescale_control};
        ADR_MODE_CTL:   rdata_o <= {8'h00, mode_and_trigger_control};
        ADR_OUT_CTL:    rdata_o <= {8'h00, output_pin_control};
        ADR_EDGE_CTL:   rdata_o <= {8'h00, edge_select_control};
        ADR_PERIOD:     rdata_o <= period_compare_reg;
        ADR_AUX1:       rdata_o <= aux_compare_reg[0];
        ADR_AUX2:       rdata_o <= aux_compare_reg[1];
        ADR_AUX3:       rdata_o <= aux_compare_reg[2];
        // Stopped counter reads zero even though it holds all ones inside
        ADR_COUNT:      rdata_o <= run_control_bit ? counter : RST_WORD;
        ADR_IRQ_STATUS: rdata_o <= {11'h000, irq_status};
        ADR_IRQ_MASK:   rdata_o <= {11'h000, irq_mask};
        default:        rdata_o <= RST_WORD;  // Unmapped reads as zero
      endcase
    end
    else
      rdata_o <= RST_WORD;
  end

  // Prescale divider: ticks every 2^select system cycles while running
  // Limitation: the divider restarts at each run, so the count clock phase
  // is tied to the start rather than to a free-running shared divider.
  // Trade-off: a predictable first interval against one common divider.
  assign div_mask   = 7'((8'h01 << clock_prescale_select) - 8'h01);
  assign presc_tick = run_control_bit & ((div_cnt & div_mask) == div_mask);

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      div_cnt <= RST_DIV;
    else if (!run_control_bit)
      div_cnt <= RST_DIV;  // Restart phase so first tick is predictable
    else
      div_cnt <= div_cnt + 7'h01;
  end

  // Event pin synchroniser; bit 0 is read only by bit 1
  // Bit 0 may go metastable on an asynchronous pin change; bit 2 keeps the
  // previous settled level for the edge compare.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ev_sync <= 3'h0;
    else
      ev_sync <= {ev_sync[1:0], event_input_pin_i};
  end

  // Edge detect on synchronised level, one pulse per chosen edge
  // Both history flops reset low, so an idle-low pin gives no false edge
  // just after reset.
  always_comb
  begin
    unique case (event_edge_select)
      EDGE_RISE: edge_pulse = ev_sync[1] & ~ev_sync[2];
      EDGE_FALL: edge_pulse = ~ev_sync[1] & ev_sync[2];
      EDGE_BOTH: edge_pulse = ev_sync[1] ^ ev_sync[2];
      default:   edge_pulse = 1'b0;                      // No edge counted
    endcase
  end

  // Count source: edges in event mode or with external clock, else prescaler
  // Only one source feeds the counter in any mode, so a tick is never
  // counted twice when a pin edge and the divider coincide.
  always_comb
  begin
    if (!run_control_bit)
      count_tick = 1'b0;
    else if (mode_event)
      count_tick = edge_pulse;
    else if (mode_interval)
      count_tick = external_clock_select ? edge_pulse : presc_tick;
    else
      count_tick = 1'b0;  // Other modes are not built here
  end

  // Compare results; the start tick from all ones is never a match
  // All compares look at the counter before this tick's update, so a match
  // and the clear that it causes fall on the same edge.
  assign period_match = count_tick & started & (counter == period_shadow);
  // Plain rollover past all ones is an overflow only when it is no match
  assign wrap_event = count_tick & started & (counter == CNT_MAX)
                      & ~period_match;

  generate
    for (k = 0; k < 3; k++)
    begin : g_aux_match
      // Aux compares above the period stay silent, even while a lowered
      // period lets the counter run on through the top of its range
      assign aux_match[k] = count_tick & started
                            & (aux_compare_reg[k] <= period_shadow)
                            & (counter == aux_compare_reg[k]);
    end
  endgenerate

  // Counter and start tracking
  // Interval mode leaves all ones on its first count tick; event mode leaves
  // it as soon as the run bit is seen, so that the first interrupt comes
  // after exactly period plus one counted edges.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      counter <= CNT_MAX;
      started <= 1'b0;
      run_q   <= 1'b0;
    end
    else
    begin
      run_q <= run_control_bit;
      if (!run_control_bit)
      begin
        counter <= CNT_MAX;  // Held at all ones until next start
        started <= 1'b0;
      end
      else if (mode_event && !started)
      begin
        // Event mode starts at once, not on the first edge
        started <= 1'b1;
        counter <= RST_WORD;
      end
      else if (count_tick)
      begin
        started <= 1'b1;
        if (!started)
          counter <= RST_WORD;  // start moves all ones to zero
        else if (period_match)
          counter <= RST_WORD;
        else
          counter <= counter + 16'h0001;  // runs through rollover
      end
    end
  end

  // Period shadow: loaded at start and by any period write while running
  // A write in the cycle after the run bit rises wins over the start load,
  // being the newer value. Lowering the period below the count while running makes the
  // counter run on through the top of its range before the next match.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      period_shadow <= RST_WORD;
    else if (wr_i && (addr_i == ADR_PERIOD))
      period_shadow <= wdata_i;
    else if (run_rise)
      period_shadow <= period_compare_reg;
  end

  // Toggle flops; only interval mode produces waveforms
  // Stopping returns every flop low, so each run starts its waveforms
  // from a known level.
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      period_out_q <= 1'b0;
      aux_out_q    <= 3'h0;
    end
    else if (!run_control_bit || !mode_interval)
    begin
      period_out_q <= 1'b0;  // no waveform outside interval mode
      aux_out_q    <= 3'h0;
    end
    else if (count_tick)
    begin
      // Start tick inverts the period pin as well as each match
      if (!started || period_match)
        period_out_q <= ~period_out_q;
      aux_out_q <= aux_out_q ^ aux_match;
    end
  end

  // Pin levels: enabled pins show the toggle flop (the period pin in interval mode only), others the idle level
  // The pins follow register bits only, with no path from the bus inputs,
  // so bus traffic alone never moves them.
  assign period_toggle_out_o = (output_pin_control[0] && mode_interval)
                               ? period_out_q : output_pin_control[1];
  generate
    for (k = 0; k < 3; k++)
    begin : g_aux_pin
      assign aux_toggle_out_o[k] = output_pin_control[2*k+2]
                                   ? aux_out_q[k] : output_pin_control[2*k+3];
    end
  endgenerate

  // Sticky interrupt status; a new event wins over a write-one clear
  // Letting the set win means an event landing on the clear is never lost;
  // software sees it at its next status read.
  assign irq_set = {wrap_event, aux_match, period_match};

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      irq_status <= RST_IRQ;
    else if (wr_i && (addr_i == ADR_IRQ_STATUS))
      irq_status <= (irq_status & ~wdata_i[4:0]) | irq_set;
    else
      irq_status <= irq_status | irq_set;
  end

  // Level interrupt while any unmasked status bit is set
  // Masking hides a bit from the pin but leaves it readable in status
  assign irq_o = |(irq_status & irq_mask);

endmodule // iec_timer_channel
`default_nettype wire

// ### test/iec_timer_channel_sva.sv
// Port checker for the interval and event counter timer channel
`timescale 1ns/1ps
`default_nettype none
module iec_timer_channel_sva
  import iec_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        event_input_pin_i,
  input wire logic        period_toggle_out_o,
  input wire logic [2:0]  aux_toggle_out_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [2:0] mode_q;  // Mode field as last written
  logic       run_q;   // Run bit as last written
  // Shadow control writes, since the mode is not visible at the ports
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_q <= MODE_INTERVAL;
      run_q  <= 1'b0;
    end
    else if (wr_i && addr_i == ADR_MODE_CTL)
      mode_q <= wdata_i[2:0];
    else if (wr_i && addr_i == ADR_RUN_CTL)
      run_q <= wdata_i[RUN_BIT];
  end
  sequence rd_narrow_s;
    rd_i && addr_i < ADR_PERIOD;
  endsequence
  sequence rd_gap_s;
    rd_i && addr_i > ADR_IRQ_MASK;
  endsequence
  rd_idle_a: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside read slot");
  rd_narrow_a: assert property (rd_narrow_s |=> rdata_o[15:8] == 8'h00)
    else $error("upper bits of byte register set");
  rd_unmapped_a: assert property (rd_gap_s |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  mask_off_a: assert property (wr_i && addr_i == ADR_IRQ_MASK && wdata_i[4:0] == 5'h00
    |=> !irq_o) else $error("irq high with all masked");
  irq_sticky_a: assert property (irq_o && !wr_i |=> irq_o)
    else $error("irq dropped without a write");
  pins_idle_a: assert property (wr_i && addr_i == ADR_OUT_CTL && wdata_i[7:0] == 8'h00
    |=> !period_toggle_out_o && aux_toggle_out_o == 3'h0) else $error("pins not idle");
  event_pin_a: assert property (mode_q == MODE_EVENT && $past(mode_q) == MODE_EVENT
    && !$past(wr_i && addr_i == ADR_OUT_CTL) |-> $stable(period_toggle_out_o))
    else $error("period pin moved in event mode");
  stop_count_a: assert property (!run_q && !$past(run_q)
    && rd_i && addr_i == ADR_COUNT |=> rdata_o == 16'h0000) else $error("count not cleared");
endmodule // iec_timer_channel_sva
`default_nettype wire

// ### test/iec_timer_channel_tb.sv
// Self-checking bench for the interval and event counter timer channel
`timescale 1ns/1ps
`default_nettype none
module iec_timer_channel_tb;
  import iec_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        event_input_pin_i = 1'b0;
  logic [15:0] rdata_o;
  logic        period_toggle_out_o;
  logic [2:0]  aux_toggle_out_o;
  logic        irq_o;
  logic [3:0]  pins;        // Period pin in bit 0, aux pins above
  logic [15:0] rv;          // Last word read
  int          mismatches = 0;
  int          checks = 0;
  int          cycles = 0;
  int          per, ticks, n, g, ps;
  assign pins = {aux_toggle_out_o, period_toggle_out_o};
  always #10 sys_clk_i = ~sys_clk_i;
  iec_timer_channel iec_timer_channel_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .event_input_pin_i(event_input_pin_i), .period_toggle_out_o(period_toggle_out_o),
    .aux_toggle_out_o(aux_toggle_out_o), .irq_o(irq_o));
  task automatic stop_test();
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    #1;  // Let the write settle before a caller looks at the outputs
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  // Cycles between two toggles of one pin; bounded so a dead pin cannot hang
  task automatic gap(input int idx);
    logic [3:0] p;
    p = pins;
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      while (pins[idx] === p[idx] && n < 4000)
      begin
        @(posedge sys_clk_i);
        #1 n++;
      end
      p = pins;
    end
  endtask
  // Whether a pin change to this level is a counted edge
  function automatic int counts(input logic [1:0] sel, input logic lvl);
    return int'((sel == EDGE_BOTH) || (sel == EDGE_RISE && lvl) || (sel == EDGE_FALL && !lvl));
  endfunction
  task automatic edge_ev(input logic [1:0] sel);
    @(posedge sys_clk_i);
    event_input_pin_i <= ~event_input_pin_i;
    ticks += counts(sel, ~event_input_pin_i);
    idle(2 + $urandom % 4);
  endtask
  // Cut a hang short
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      mismatches++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(32'h86cb));
    idle(10);
    rst_n_i <= 1'b1;
    wr(ADR_COUNT, 16'h1234);
    rd(ADR_COUNT);
    chk("count", RST_WORD, rv);
    rd(4'hF);
    chk("unmapped", 16'h0000, rv);
    // Zero period: counter pinned at zero, pin toggles each tick
    wr(ADR_OUT_CTL, 16'h0055);
    wr(ADR_IRQ_MASK, 16'h001F);
    wr(ADR_RUN_CTL, 16'h0080);
    idle(4);
    rd(ADR_COUNT);
    chk("zero period count", 16'h0000, rv);
    gap(0);
    chk("zero period gap", 16'h0001, n[15:0]);
    chk("irq", 16'h0001, {15'h0000, irq_o});
    // Random period with one aux above and two below it
    wr(ADR_RUN_CTL, 16'h0000);
    per = 8 + $urandom % 40;
    wr(ADR_PERIOD, per[15:0]);
    wr(ADR_AUX1, 16'($urandom % per));
    wr(ADR_AUX2, 16'(per + 1 + $urandom % 50));
    wr(ADR_AUX3, 16'h0000);
    wr(ADR_IRQ_STATUS, 16'h001F);
    ps = $urandom % 3;
    wr(ADR_RUN_CTL, {8'h00, 8'h80 | 8'(ps)});
    gap(0);
    chk("period gap", 16'((per + 1) << ps), n[15:0]);
    gap(1);
    chk("aux1 gap", 16'((per + 1) << ps), n[15:0]);
    gap(3);
    chk("aux3 gap", 16'((per + 1) << ps), n[15:0]);
    chk("aux2 level", 16'h0000, {15'h0000, aux_toggle_out_o[1]});
    rd(ADR_IRQ_STATUS);
    chk("status", 16'h000B, rv);
    // Full period: match at the top, wrap flag stays clear
    wr(ADR_RUN_CTL, 16'h0000);
    wr(ADR_PERIOD, CNT_MAX);
    wr(ADR_IRQ_STATUS, 16'h001F);
    wr(ADR_IRQ_MASK, 16'h0000);
    chk("masked irq", 16'h0000, {15'h0000, irq_o});
    wr(ADR_RUN_CTL, 16'h0080);
    idle(65545);
    rd(ADR_IRQ_STATUS);
    chk("full period", 16'h0001, rv & 16'h0011);
    wr(ADR_IRQ_MASK, 16'h0001);
    chk("unmasked irq", 16'h0001, {15'h0000, irq_o});
    // Lowering the period to a value above the count takes effect at once
    wr(ADR_RUN_CTL, 16'h0000);
    wr(ADR_PERIOD, 16'h03E8);
    wr(ADR_RUN_CTL, 16'h0080);
    idle(5);
    wr(ADR_PERIOD, 16'h001E);
    wr(ADR_IRQ_STATUS, 16'h001F);
    idle(40);
    rd(ADR_IRQ_STATUS);
    chk("new period", 16'h0001, rv & 16'h0001);
    // Lowering below the count runs on to the wrap
    wr(ADR_RUN_CTL, 16'h0000); // Stop and restart so the count begins again from zero
    wr(ADR_RUN_CTL, 16'h0080);
    idle(20);
    wr(ADR_PERIOD, 16'h0005);
    wr(ADR_IRQ_STATUS, 16'h001F);
    idle(300);
    rd(ADR_IRQ_STATUS);
    chk("lowered period", 16'h0000, rv & 16'h0001);
    // Event count under every edge selection
    wr(ADR_RUN_CTL, 16'h0000);
    wr(ADR_MODE_CTL, {13'h0000, MODE_EVENT});
    per = 2 + $urandom % 5;
    wr(ADR_PERIOD, per[15:0]);
    for (int m = 0; m < 4; m++)
    begin
      wr(ADR_RUN_CTL, 16'h0000);
      wr(ADR_EDGE_CTL, 16'(m << EDGE_LSB));
      wr(ADR_IRQ_STATUS, 16'h001F);
      wr(ADR_RUN_CTL, 16'h0080);
      rd(ADR_COUNT);
      chk("event start", RST_WORD, rv);
      ticks = 0;
      for (g = 0; ticks < per && g < 20; g++)
        edge_ev(2'(m));
      idle(4);
      rd(ADR_IRQ_STATUS);
      chk("before match", 16'h0000, rv & 16'h0001);
      for (g = 0; ticks < per + 1 && g < 6; g++)
        edge_ev(2'(m));
      idle(4);
      rd(ADR_IRQ_STATUS);
      chk("event match", 16'(m != 0), rv & 16'h0001);
    end
    // Interval mode clocked by pin edges: start, one count, then match
    wr(ADR_RUN_CTL, 16'h0000);
    wr(ADR_MODE_CTL, 16'h0020);
    wr(ADR_EDGE_CTL, 16'h000C);
    wr(ADR_PERIOD, 16'h0001);
    wr(ADR_IRQ_STATUS, 16'h001F);
    wr(ADR_RUN_CTL, 16'h0080);
    edge_ev(EDGE_BOTH);
    edge_ev(EDGE_BOTH);
    idle(4);
    chk("ext clock pin", 16'h0001, {15'h0000, period_toggle_out_o});
    rd(ADR_IRQ_STATUS);
    chk("ext clock early", 16'h0000, rv & 16'h0001);
    edge_ev(EDGE_BOTH);
    idle(4);
    rd(ADR_IRQ_STATUS);
    chk("ext clock match", 16'h0001, rv & 16'h0001);
    stop_test();
  end
endmodule // iec_timer_channel_tb
bind iec_timer_channel iec_timer_channel_sva iec_timer_channel_sva_inst (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_input_pin_i(event_input_pin_i),
  .period_toggle_out_o(period_toggle_out_o), .aux_toggle_out_o(aux_toggle_out_o),
  .irq_o(irq_o));
`default_nettype wire
